// File: mce_pkg.sv
// Shared constants and types for the Manchester encoder and decoder output block
`default_nettype none
package mce_pkg;
   // Decoder recognition register and sync pattern
   localparam int           SR_LEN      = 10;
   localparam logic [5:0]   SYNC_PAT    = 6'h38;
   localparam int           HALF_A_POS  = 3;
   localparam int           HALF_B_POS  = 2;
   localparam int           TAIL_A_POS  = 1;
   localparam int           TAIL_B_POS  = 0;
   // Clock synchronizer low time, in oscillator cycles
   localparam logic [3:0]   LOW_CNT_16  = 4'h4;
   localparam logic [3:0]   LOW_CNT_32  = 4'h8;
   // Bit period divider: last count, half-bit count and start count, in oscillator cycles
   localparam logic [4:0]   OVS_16_LAST = 5'h0f;
   localparam logic [4:0]   OVS_32_LAST = 5'h1f;
   localparam logic [4:0]   HALF_16     = 5'h08;
   localparam logic [4:0]   HALF_32     = 5'h10;
   localparam logic [4:0]   DIV_START   = 5'h00;
   // Reset delays, in synchronous 2x clock rises
   localparam logic [1:0]   RST_DLY     = 2'h2;
   // Encoder preamble, sync and tail timing
   localparam logic [3:0]   ZCNT_SYNC   = 4'h8;
   localparam logic [3:0]   ZCNT_DATA   = 4'hb;
   localparam logic [2:0]   SYNC_HALVES = 3'h3;
   localparam logic [1:0]   TAIL_FIRST  = 2'h1;
   localparam logic [1:0]   TAIL_END    = 2'h3;
   // Pin synchronizer lanes
   localparam int           PIN_N       = 5;
   localparam int           PIN_MRST    = 0;
   localparam int           PIN_TXREQ   = 1;
   localparam int           PIN_NRZ     = 2;
   localparam int           PIN_SPEED   = 3;
   localparam int           PIN_REPEAT  = 4;
   localparam logic [4:0]   PIN_IDLE    = 5'h07;

   typedef enum logic [2:0] {
      MCE_IDLE = 3'b000,
      MCE_PRE  = 3'b001,
      MCE_SYNC = 3'b010,
      MCE_DATA = 3'b011,
      MCE_TAIL = 3'b100
   } mce_enc_state_t;
endpackage
`default_nettype wire

// File: mce_pair_buffer.sv
// Two-entry valid/ready buffer for the decoded bit stream
`default_nettype none
module mce_pair_buffer #(
   parameter int DATA_W = 1
) (
   // Clock and control
   input  wire logic              ref_clk_in,
   input  wire logic              rst_n_in,
   input  wire logic              ce_in,
   // Filling side
   input  wire logic              in_valid_in,
   input  wire logic [DATA_W-1:0] in_data_in,
   output logic                   in_ready_out,
   // Draining side
   output logic                   out_valid_out,
   output logic [DATA_W-1:0]      out_data_out,
   input  wire logic              out_ready_in
);
   logic [DATA_W-1:0] slot1_r;
   logic              full1_r;
   logic              push;
   logic              pop;

   // Head always sits in the output register, so the port comes straight from a flop
   assign in_ready_out = ~full1_r;
   assign push         = in_valid_in & ~full1_r;
   assign pop          = out_valid_out & out_ready_in;

   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         out_valid_out <= 1'b0;
         out_data_out  <= '0;
         full1_r       <= 1'b0;
         slot1_r       <= '0;
      end else if (ce_in) begin
         if (pop && full1_r) begin
            out_data_out <= slot1_r;
            full1_r      <= push;
            if (push) begin
               slot1_r <= in_data_in;
            end
         end else if (pop) begin
            out_valid_out <= push;
            if (push) begin
               out_data_out <= in_data_in;
            end
         end else if (push && !out_valid_out) begin
            out_data_out  <= in_data_in;
            out_valid_out <= 1'b1;
         end else if (push) begin
            slot1_r <= in_data_in;
            full1_r <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// File: mce_codec.sv
// Manchester encoder and decoder output stage
`default_nettype none
// Overview of operation
// (R1) Present decoded bit as decoded clock rises
// (R2) Shift line data on each 2x rise
// (R3) Word start: sync pulse plus two bits
// (R4) Raise valid flag edge after recognition
// (R5) Force decoded clock high on that edge
// (R6) First data bit appears on that edge
// (R7) Later bits on alternate 2x rises
// (R8) Invalid data drops valid after three periods
// (R9) Master reset drops serial reset one later
// (R10) Master reset clears decoder outputs two later
// (R11) Divider makes free 1x and 2x clocks
// (R12) Mode picks host data or line data
// (R13) Encoder clock from 2x or 1x per mode
// (R14) Idle: outputs high, encoder clock low
// (R15) Request captured at 1x falling edge
// (R16) Preamble outputs follow 1x clock
// (R17) Zeros count eight enables sync pulse
// (R18) Count eleven ends sync, data follows
// (R19) Encoder clock is inverted 1x clock
// (R20) Encoder clock fall captures bit, rise outputs it
// (R21) Next 2x rise inverts, completing bit
// (R22) Request release: clock low, last bit
// (R23) After last bit outputs return high
// (R24) Sync: three halves each line state
// (R25) 2x sync clock from low-time counter
// (R26) Master reset idles encoder, outputs high
module mce_codec #(
   parameter int DATA_W = 1
) (
   // Clock, reset, enable
   input  wire logic              ref_clk_in,
   input  wire logic              rst_n_in,
   input  wire logic              ce_in,
   // Configuration pins
   input  wire logic              speed_32x_in,
   input  wire logic              repeater_mode_in,
   // Decoder front end
   input  wire logic              pll_data_in,
   input  wire logic              dpll_sample_in,
   input  wire logic              master_reset_n_in,
   // Decoder outputs
   output logic                   serial_nrz_out,
   output logic                   decoded_bit_clock_out,
   output logic                   valid_word_indicator_n_out,
   output logic                   serial_reset_out_n_out,
   // Decoded bit stream
   output logic                   dec_valid_out,
   output logic [DATA_W-1:0]      dec_data_out,
   input  wire logic              dec_ready_in,
   // Encoder host side
   input  wire logic              transmit_request_n_in,
   input  wire logic              nrz_serial_in,
   // Encoder line side
   output logic                   bipolar_one_out_n_out,
   output logic                   bipolar_zero_out_n_out,
   output logic                   encoder_bit_clock_out
);
   logic [mce_pkg::PIN_N-1:0]  pin_meta_r;
   logic [mce_pkg::PIN_N-1:0]  pin_sync_r;
   logic                       mrst_s;
   logic                       txreq_n_s;
   logic                       nrz_s;
   logic                       fast_s;
   logic                       repeat_s;
   logic [mce_pkg::PIN_N-1:0]  pin_raw;

   logic [3:0]                 low_cnt_r;
   logic [3:0]                 low_tgt;
   logic                       sync2x_r;
   logic                       rise2x;
   logic [1:0]                 rst_cnt_r;
   logic [mce_pkg::SR_LEN-1:0] sr_r;
   logic                       push_r;
   logic [DATA_W-1:0]          push_data_r;

   logic [4:0]                 div_r;
   logic [4:0]                 div_nxt;
   logic [4:0]                 div_last;
   logic [4:0]                 div_half;
   logic                       clk1x_nxt;
   logic                       f1;
   logic                       r2;

   mce_pkg::mce_enc_state_t    st_r;
   logic [3:0]                 zcnt_r;
   logic [2:0]                 sg_r;
   logic [1:0]                 tail_r;
   logic                       cap_r;
   logic                       have_r;

   // Word start: sync 111000 or 000111, then two bits with mid-bit edges
   function automatic logic word_start(input logic [mce_pkg::SR_LEN-1:0] sr);
      logic sync_ok;
      sync_ok = (sr[mce_pkg::SR_LEN-1:mce_pkg::HALF_A_POS+1] == mce_pkg::SYNC_PAT) ||
                (sr[mce_pkg::SR_LEN-1:mce_pkg::HALF_A_POS+1] == ~mce_pkg::SYNC_PAT);
      return sync_ok &&
             (sr[mce_pkg::HALF_A_POS] != sr[mce_pkg::HALF_B_POS]) &&
             (sr[mce_pkg::TAIL_A_POS] != sr[mce_pkg::TAIL_B_POS]);
   endfunction

   // Pin synchronizers; first stage feeds only the second
   assign pin_raw = {repeater_mode_in, speed_32x_in, nrz_serial_in,
                     transmit_request_n_in, master_reset_n_in};

   genvar gi;
   generate
      for (gi = 0; gi < mce_pkg::PIN_N; gi++) begin : g_pin
         always_ff @(posedge ref_clk_in) begin
            if (!rst_n_in) begin
               pin_meta_r[gi] <= mce_pkg::PIN_IDLE[gi];
               pin_sync_r[gi] <= mce_pkg::PIN_IDLE[gi];
            end else if (ce_in) begin
               pin_meta_r[gi] <= pin_raw[gi];
               pin_sync_r[gi] <= pin_meta_r[gi];
            end
         end
      end
   endgenerate

   assign mrst_s    = pin_sync_r[mce_pkg::PIN_MRST];
   assign txreq_n_s = pin_sync_r[mce_pkg::PIN_TXREQ];
   assign nrz_s     = pin_sync_r[mce_pkg::PIN_NRZ];
   assign fast_s    = pin_sync_r[mce_pkg::PIN_SPEED];
   assign repeat_s  = pin_sync_r[mce_pkg::PIN_REPEAT];

   // Synchronous 2x clock: low for a fixed count, high until the next sample
   assign low_tgt = fast_s ? mce_pkg::LOW_CNT_32 : mce_pkg::LOW_CNT_16;
   assign rise2x  = ~sync2x_r & ~dpll_sample_in & (low_cnt_r == low_tgt - 4'h1);

   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         low_cnt_r <= '0;
         sync2x_r  <= 1'b0;
      end else if (ce_in) begin
         if (dpll_sample_in) begin
            low_cnt_r <= '0; // (R25)
            sync2x_r  <= 1'b0; // (R25)
         end else if (rise2x) begin
            sync2x_r  <= 1'b1; // (R25)
         end else if (!sync2x_r) begin
            low_cnt_r <= low_cnt_r + 4'h1; // (R25)
         end
      end
   end

   // Serial reset follows the synchronized master reset by one cycle
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         serial_reset_out_n_out <= 1'b0;
      end else if (ce_in) begin
         serial_reset_out_n_out <= mrst_s; // (R9)
      end
   end

   // Counts 2x rises while master reset is held
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         rst_cnt_r <= '0;
      end else if (ce_in) begin
         if (mrst_s) begin
            rst_cnt_r <= '0;
         end else if (rise2x && rst_cnt_r != mce_pkg::RST_DLY) begin
            rst_cnt_r <= rst_cnt_r + 2'h1;
         end
      end
   end

   // Recognition register
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         sr_r <= '0;
      end else if (ce_in && rise2x) begin
         sr_r <= {sr_r[mce_pkg::SR_LEN-2:0], pll_data_in}; // (R2)
      end
   end

   // Decoder outputs; a bit is the inverse of its first half on the line
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         serial_nrz_out             <= 1'b0;
         decoded_bit_clock_out      <= 1'b0;
         valid_word_indicator_n_out <= 1'b0;
         push_r                     <= 1'b0;
         push_data_r                <= '0;
      end else if (ce_in) begin
         push_r <= 1'b0;
         if (rise2x) begin
            if (!mrst_s && rst_cnt_r >= mce_pkg::RST_DLY - 2'h1) begin
               serial_nrz_out             <= 1'b0; // (R10)
               decoded_bit_clock_out      <= 1'b0; // (R10)
               valid_word_indicator_n_out <= 1'b0; // (R10)
            end else if (word_start(sr_r)) begin // (R3)
               valid_word_indicator_n_out <= 1'b1; // (R4)
               decoded_bit_clock_out      <= 1'b1; // (R5)
               serial_nrz_out             <= ~sr_r[mce_pkg::HALF_A_POS]; // (R6)
               push_r                     <= 1'b1;
               push_data_r                <= DATA_W'(~sr_r[mce_pkg::HALF_A_POS]);
            end else begin
               decoded_bit_clock_out <= ~decoded_bit_clock_out; // (R7)
               if (!decoded_bit_clock_out && valid_word_indicator_n_out) begin
                  // Pair checked three rises after its second half entered
                  if (sr_r[mce_pkg::HALF_A_POS] != sr_r[mce_pkg::HALF_B_POS]) begin
                     serial_nrz_out <= ~sr_r[mce_pkg::HALF_A_POS]; // (R1)
                     push_r         <= 1'b1;
                     push_data_r    <= DATA_W'(~sr_r[mce_pkg::HALF_A_POS]);
                  end else begin
                     valid_word_indicator_n_out <= 1'b0; // (R8)
                  end
               end
            end
         end
      end
   end

   // Absorbs a stall by the reader; a bit pushed while both entries are full is dropped
   mce_pair_buffer #(
      .DATA_W (DATA_W)
   ) u_buf (
      .ref_clk_in    (ref_clk_in),
      .rst_n_in      (rst_n_in),
      .ce_in         (ce_in),
      .in_valid_in   (push_r),
      .in_data_in    (push_data_r),
      .in_ready_out  (),
      .out_valid_out (dec_valid_out),
      .out_data_out  (dec_data_out),
      .out_ready_in  (dec_ready_in)
   );

   // Free-running divider; edges are taken from the next count
   assign div_last  = fast_s ? mce_pkg::OVS_32_LAST : mce_pkg::OVS_16_LAST;
   assign div_half  = fast_s ? mce_pkg::HALF_32 : mce_pkg::HALF_16;
   assign div_nxt   = (div_r >= div_last) ? mce_pkg::DIV_START : div_r + 5'h01;
   assign clk1x_nxt = div_nxt < div_half;
   assign f1        = div_nxt == div_half;
   assign r2        = f1 | (div_nxt == mce_pkg::DIV_START);

   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         div_r <= mce_pkg::DIV_START;
      end else if (ce_in) begin
         div_r <= div_nxt; // (R11)
      end
   end

   // Encoder sequencer and line outputs
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in || (ce_in && !mrst_s)) begin
         st_r                   <= mce_pkg::MCE_IDLE; // (R26)
         zcnt_r                 <= '0;
         sg_r                   <= '0;
         tail_r                 <= '0;
         cap_r                  <= 1'b0;
         have_r                 <= 1'b0;
         bipolar_one_out_n_out  <= 1'b1; // (R26)
         bipolar_zero_out_n_out <= 1'b1; // (R26)
         encoder_bit_clock_out  <= 1'b0;
      end else if (ce_in && repeat_s) begin
         st_r <= mce_pkg::MCE_IDLE;
         if (txreq_n_s) begin
            bipolar_one_out_n_out  <= 1'b1; // (R14)
            bipolar_zero_out_n_out <= 1'b1; // (R14)
            encoder_bit_clock_out  <= 1'b0; // (R14)
         end else begin
            encoder_bit_clock_out <= sync2x_r; // (R13)
            if (rise2x) begin
               bipolar_one_out_n_out  <= pll_data_in; // (R12)
               bipolar_zero_out_n_out <= ~pll_data_in; // (R12)
            end
         end
      end else if (ce_in) begin
         unique case (st_r)
            mce_pkg::MCE_IDLE: begin
               bipolar_one_out_n_out  <= 1'b1; // (R14)
               bipolar_zero_out_n_out <= 1'b1; // (R14)
               encoder_bit_clock_out  <= 1'b0; // (R14)
               zcnt_r                 <= '0;
               if (f1 && !txreq_n_s) begin
                  st_r <= mce_pkg::MCE_PRE; // (R15)
               end
            end
            mce_pkg::MCE_PRE: begin
               if (f1) begin
                  zcnt_r <= zcnt_r + 4'h1; // (R17)
               end
               if (r2 && zcnt_r >= mce_pkg::ZCNT_SYNC) begin
                  st_r                   <= mce_pkg::MCE_SYNC; // (R17)
                  sg_r                   <= 3'h1;
                  bipolar_one_out_n_out  <= 1'b0; // (R24)
                  bipolar_zero_out_n_out <= 1'b1; // (R24)
               end else if (r2) begin
                  bipolar_one_out_n_out  <= clk1x_nxt; // (R16)
                  bipolar_zero_out_n_out <= ~clk1x_nxt; // (R16)
               end
            end
            mce_pkg::MCE_SYNC: begin
               if (f1) begin
                  zcnt_r <= zcnt_r + 4'h1; // (R17)
               end
               if (r2) begin
                  sg_r                   <= sg_r + 3'h1;
                  bipolar_one_out_n_out  <= sg_r >= mce_pkg::SYNC_HALVES; // (R24)
                  bipolar_zero_out_n_out <= sg_r < mce_pkg::SYNC_HALVES; // (R24)
               end
               if (f1 && zcnt_r == mce_pkg::ZCNT_DATA - 4'h1) begin
                  st_r   <= mce_pkg::MCE_DATA; // (R18)
                  have_r <= 1'b0;
               end
            end
            mce_pkg::MCE_DATA: begin
               if (r2) begin
                  encoder_bit_clock_out <= ~clk1x_nxt; // (R19)
                  if (encoder_bit_clock_out && clk1x_nxt) begin
                     cap_r  <= nrz_s; // (R20)
                     have_r <= 1'b1;
                     if (have_r) begin
                        bipolar_one_out_n_out  <= ~bipolar_one_out_n_out; // (R21)
                        bipolar_zero_out_n_out <= ~bipolar_zero_out_n_out; // (R21)
                     end
                  end else if (!encoder_bit_clock_out && !clk1x_nxt && have_r) begin
                     bipolar_one_out_n_out  <= ~cap_r; // (R20)
                     bipolar_zero_out_n_out <= cap_r; // (R20)
                  end
               end
               // Old captured bit drives the outputs while the last bit is taken
               if (f1 && txreq_n_s) begin
                  st_r                  <= mce_pkg::MCE_TAIL; // (R22)
                  encoder_bit_clock_out <= 1'b0; // (R22)
                  cap_r                 <= nrz_s; // (R22)
                  tail_r                <= '0;
               end
            end
            mce_pkg::MCE_TAIL: begin
               encoder_bit_clock_out <= 1'b0;
               if (r2) begin
                  tail_r <= tail_r + 2'h1;
                  if (tail_r == mce_pkg::TAIL_END) begin
                     st_r                   <= mce_pkg::MCE_IDLE;
                     bipolar_one_out_n_out  <= 1'b1; // (R23)
                     bipolar_zero_out_n_out <= 1'b1; // (R23)
                  end else if (tail_r == mce_pkg::TAIL_FIRST) begin
                     bipolar_one_out_n_out  <= ~cap_r; // (R22)
                     bipolar_zero_out_n_out <= cap_r; // (R22)
                  end else begin
                     bipolar_one_out_n_out  <= ~bipolar_one_out_n_out; // (R21)
                     bipolar_zero_out_n_out <= ~bipolar_zero_out_n_out; // (R21)
                  end
               end
            end
            default: begin
               st_r <= mce_pkg::MCE_IDLE;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// File: mce_codec_assertions.sv
// Concurrent checks on the codec top ports
`default_nettype none
module mce_codec_assertions (
   // Clock and resets
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic master_reset_n_in,
   // Watched pins
   input wire logic transmit_request_n_in,
   input wire logic serial_nrz_out,
   input wire logic decoded_bit_clock_out,
   input wire logic valid_word_indicator_n_out,
   input wire logic serial_reset_out_n_out,
   input wire logic bipolar_one_out_n_out,
   input wire logic bipolar_zero_out_n_out,
   input wire logic encoder_bit_clock_out
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] idle_cnt_r;
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);
   // Long host silence, just past the longest tail (32x), means the encoder must sit idle
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in || !transmit_request_n_in) begin
         idle_cnt_r <= 8'h00;
      end else if (idle_cnt_r != 8'hff) begin
         idle_cnt_r <= idle_cnt_r + 8'h01;
      end
   end
   sequence dec_cleared;
      !decoded_bit_clock_out && !valid_word_indicator_n_out && !serial_nrz_out;
   endsequence
   sequence clk_high_hold;
      decoded_bit_clock_out [*6];
   endsequence
   start_forces_clock_a : assert property (
      $rose(valid_word_indicator_n_out) |-> decoded_bit_clock_out)
      else $error("valid rose without bit clock high");
   bit_on_clock_a : assert property (
      $changed(serial_nrz_out) |-> $rose(decoded_bit_clock_out)
      || $rose(valid_word_indicator_n_out) || !serial_reset_out_n_out)
      else $error("decoded bit changed off a bit clock rise");
   clock_high_hold_a : assert property (
      $rose(decoded_bit_clock_out) && serial_reset_out_n_out |=> clk_high_hold)
      else $error("bit clock high time too short");
   serial_reset_delay_a : assert property (
      $fell(master_reset_n_in) |-> ##3 !serial_reset_out_n_out)
      else $error("serial reset late");
   decoder_clear_a : assert property (
      $fell(serial_reset_out_n_out) |-> ##[1:24] dec_cleared)
      else $error("decoder outputs not cleared");
   idle_outputs_a : assert property (
      (idle_cnt_r >= 8'h64 || !serial_reset_out_n_out) |-> bipolar_one_out_n_out
      && bipolar_zero_out_n_out && !encoder_bit_clock_out)
      else $error("encoder not idle");
   one_spacing_a : assert property (
      $changed(bipolar_one_out_n_out) |=> $stable(bipolar_one_out_n_out) [*7])
      else $error("line output half period too short");
   encoder_bit_clock_spacing_a : assert property (
      $changed(encoder_bit_clock_out) |=> $stable(encoder_bit_clock_out) [*7])
      else $error("encoder clock half period too short");
   never_both_low_a : assert property (
      bipolar_one_out_n_out || bipolar_zero_out_n_out)
      else $error("both line outputs low");
endmodule
bind mce_codec mce_codec_assertions u_chk (
   .ref_clk_in(ref_clk_in),
   .rst_n_in(rst_n_in),
   .master_reset_n_in(master_reset_n_in),
   .transmit_request_n_in(transmit_request_n_in),
   .serial_nrz_out(serial_nrz_out),
   .decoded_bit_clock_out(decoded_bit_clock_out),
   .valid_word_indicator_n_out(valid_word_indicator_n_out),
   .serial_reset_out_n_out(serial_reset_out_n_out),
   .bipolar_one_out_n_out(bipolar_one_out_n_out),
   .bipolar_zero_out_n_out(bipolar_zero_out_n_out),
   .encoder_bit_clock_out(encoder_bit_clock_out)
);
`default_nettype wire

// File: mce_line_model.sv
// Line and phase lock stand-in feeding the decoder
`default_nettype none
module mce_line_model (
   // Clock and reset
   input  wire logic        ref_clk_in,
   input  wire logic        rst_n_in,
   // Word to send, one half-bit per entry, entry 0 first
   input  wire logic        go_in,
   input  wire logic [31:0] word_in,
   input  wire logic [4:0]  len_in,
   // Recovered line toward the decoder
   output logic             pll_data_out,
   output logic             dpll_sample_out,
   output logic             busy_out
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [2:0] tick_r;
   logic [4:0] idx_r;
   // Sample every eight cycles keeps the 2x clock at its nominal times
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         tick_r <= 3'h0;
         dpll_sample_out <= 1'b0;
      end else begin
         tick_r <= tick_r + 3'h1;
         dpll_sample_out <= (tick_r == 3'h7);
      end
   end
   // Idle line sits high, which never pairs into a valid bit
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         busy_out <= 1'b0;
         idx_r <= 5'h00;
         pll_data_out <= 1'b1;
      end else if (go_in) begin
         busy_out <= 1'b1;
         idx_r <= 5'h00;
      end else if (tick_r == 3'h7) begin
         pll_data_out <= busy_out ? word_in[idx_r] : 1'b1;
         idx_r <= idx_r + 5'h01;
         busy_out <= busy_out && (idx_r != len_in - 5'h01);
      end
   end
endmodule
`default_nettype wire

// File: test_mce_codec.sv
// Self-checking bench for the Manchester codec
`default_nettype none
module test_mce_codec;
   timeunit 1ns;
   timeprecision 100ps;
   // Sync 111000, then bits 1 0 1 1 0 0 as inverted-first half pairs
   localparam logic [31:0] WORD     = 32'h0001_6987;
   localparam logic [4:0]  DEC_BITS = 5'h0d;
   localparam logic [5:0]  ENC_BITS = 6'h19;
   logic       clk;
   logic       rst_n;
   logic       mrst_n;
   logic       txreq_n;
   logic       nrz;
   logic       ready;
   logic       go;
   logic       line;
   logic       smp;
   logic       d_nrz;
   logic       d_clk;
   logic       d_valid;
   logic       serial_reset_out_n_n;
   logic       dv;
   logic [0:0] dd;
   logic       one_n;
   logic       zero_n;
   logic       encoder_bit_clock;
   logic       cur;
   logic       pv;
   logic       pd;
   int         i;
   int         k;
   int         len;
   int         n_mismatch;
   int         n_compared;

   mce_line_model u_line (.ref_clk_in(clk), .rst_n_in(rst_n), .go_in(go), .word_in(WORD),
      .len_in(5'h12), .pll_data_out(line), .dpll_sample_out(smp), .busy_out());
   mce_codec u_dut (.ref_clk_in(clk), .rst_n_in(rst_n), .ce_in(1'b1), .speed_32x_in(1'b0),
      .repeater_mode_in(1'b0), .pll_data_in(line), .dpll_sample_in(smp),
      .master_reset_n_in(mrst_n), .serial_nrz_out(d_nrz), .decoded_bit_clock_out(d_clk),
      .valid_word_indicator_n_out(d_valid), .serial_reset_out_n_out(serial_reset_out_n_n),
      .dec_valid_out(dv), .dec_data_out(dd), .dec_ready_in(ready),
      .transmit_request_n_in(txreq_n), .nrz_serial_in(nrz),
      .bipolar_one_out_n_out(one_n), .bipolar_zero_out_n_out(zero_n),
      .encoder_bit_clock_out(encoder_bit_clock));

   always #2 clk = ~clk;

   function automatic logic pick(input int sel);
      case (sel)
         0: pick = d_valid;
         1: pick = encoder_bit_clock;
         2: pick = one_n;
         3: pick = dv;
         default: pick = one_n & zero_n;
      endcase
   endfunction

   task automatic conclude();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk_bit(input logic exp, input logic got);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: expected %b got %b", $time, exp, got);
      end
   endtask

   task automatic chk_len(input int exp, input int got);
      n_compared++;
      if (got != exp) begin
         n_mismatch++;
         $display("mismatch at %0t: run of %0d, expected %0d", $time, got, exp);
      end
   endtask

   // Bounded wait for a watched output to reach a level
   task automatic wait_lvl(input int sel, input logic lvl, input int lim);
      int t;
      for (t = 0; t < lim && pick(sel) !== lvl; t++) begin
         @(posedge clk);
      end
      if (t == lim) begin
         n_mismatch++;
         $display("mismatch at %0t: wait ran out", $time);
         conclude();
      end
   endtask

   task automatic send();
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
   endtask

   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      mrst_n = 1'b1;
      txreq_n = 1'b1;
      nrz = 1'b1;
      ready = 1'b0;
      go = 1'b0;
      pv = 1'b0;
      pd = 1'b0;
      n_mismatch = 0;
      n_compared = 0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      // Decode one word with the reader stalled, then let the idle line break it
      send();
      k = 0;
      for (i = 0; i < 600 && k < 5; i++) begin
         @(posedge clk);
         if (d_valid === 1'b1 && (!pv || (d_clk === 1'b1 && !pd))) begin
            chk_bit(DEC_BITS[k], d_nrz);
            k++;
         end
         pv = d_valid;
         pd = d_clk;
      end
      chk_len(5, k);
      wait_lvl(0, 0, 200);
      // Only the first two bits fit the buffer while the reader stalled
      ready <= 1'b1;
      @(posedge clk);
      for (k = 0; k < 2; k++) begin
         wait_lvl(3, 1, 20);
         chk_bit(DEC_BITS[k], dd[0]);
         @(posedge clk);
      end
      chk_bit(1'b0, dv);
      // Preamble and sync measured as run lengths of the one line
      txreq_n <= 1'b0;
      wait_lvl(2, 0, 300);
      for (k = 0; k < 16; k++) begin
         cur = one_n;
         len = 0;
         do begin
            @(posedge clk);
            len++;
         end while (one_n === cur && len < 100);
         if (k < 14) chk_len(8, len);
         else if (k == 14) chk_len(32, len);
         else chk_bit(1'b1, len >= 24);
      end
      // A bit driven after one encoder clock rise shows after the next rise
      for (k = 0; k < 7; k++) begin
         wait_lvl(1, 0, 40);
         wait_lvl(1, 1, 40);
         repeat (2) @(posedge clk);
         if (k > 0) begin
            chk_bit(~ENC_BITS[k-1], one_n);
            chk_bit(ENC_BITS[k-1], zero_n);
         end
         if (k < 6) nrz <= ENC_BITS[k];
      end
      txreq_n <= 1'b1;
      wait_lvl(4, 1, 100);
      chk_bit(1'b0, encoder_bit_clock);
      // Master reset in the middle of a decoded word
      send();
      wait_lvl(0, 1, 400);
      mrst_n <= 1'b0;
      wait_lvl(0, 0, 40);
      chk_bit(1'b0, serial_reset_out_n_n);
      chk_bit(1'b0, d_clk);
      chk_bit(1'b0, d_nrz);
      mrst_n <= 1'b1;
      repeat (4) @(posedge clk);
      chk_bit(1'b1, serial_reset_out_n_n);
      conclude();
   end
endmodule
`default_nettype wire
